/* File: inc/hdlc_cfg.svh */
// constants for the hdlc transmit fifo, command and status block
// assumes inclusion by bare name from the modules; package and interface do not include it
`ifndef HDLC_CFG_SVH
`define HDLC_CFG_SVH
// channel address map (byte addresses on the host side of the device)
`define FIFO_A_LO        7'h00
`define FIFO_A_HI        7'h1f
`define FIFO_B_LO        7'h40
`define FIFO_B_HI        7'h5f
`define STATUS_CMD_A     7'h20
`define STATUS_CMD_B     7'h60
`define MODE_A           7'h22
`define TIMER_A          7'h23
`define COUNT_LOW_A      7'h2a
`define COUNT_HIGH_A     7'h2b
// fifo sizing
`define FIFO_BYTES       6'h20
`define BLOCK_BYTES      6'h20
// channel_status field positions and reset value
`define ST_OVERFLOW      7
`define ST_WRITE_EN      6
`define ST_LOCAL_NR      5
`define ST_REMOTE_NR     4
`define ST_LINE_IDLE     3
`define ST_CMD_EXEC      2
`define ST_CTS           1
`define ST_AWAIT_ACK     0
`define STATUS_RESET     8'h48
// command_strobes bit positions and the cyclic command value
`define CMD_RX_RELEASE   7
`define CMD_RX_RESET     6
`define CMD_REPEAT       5
`define CMD_TIMER_GO     4
`define CMD_SEND_TF      3
`define CMD_SEND_IF      2
`define CMD_MSG_END      1
`define CMD_TX_RESET     0
`define CMD_CYCLIC       8'h2a
// mode register fields and the dma bit of the count high register
`define MODE_SEL_HI      7
`define MODE_SEL_LO      6
`define COUNT_DMA_BIT    7
// timing: command busy bound 2.5 clock periods, link clock divider
`define CMD_BUSY_NS      250
`define CLK_NS           100
`define CMD_BUSY_CYC     (`CMD_BUSY_NS / `CLK_NS)
`define BIT_DIV          4'h3
`define ABORT_ONES       3'h7
`define IDLE_LIMIT       8'h40
`define FLAG_BYTE        8'h7e
`endif

/* File: inc/hdlc_pkg.sv */
// types used by the device end; the host end does not import them
// assumes hdlc_cfg.svh on the include path
package hdlc_pkg;
	typedef enum logic [1:0] {
		mode_auto,
		mode_non_auto,
		mode_transparent,
		mode_ext_transparent
	} controller_mode_t;
	typedef enum {
		tx_idle,
		tx_flag_open,
		tx_data,
		tx_flag_close,
		tx_abort,
		tx_cyclic
	} tx_state_t;
endpackage : hdlc_pkg

/* File: inc/hdlc_if.sv */
// interface between host controller and hdlc channel device
// assumes one shared clock; byte-wide register port, serial link pins
`timescale 1ns/1ps
interface hdlc_if;
	// register port
	logic [6:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic       word_mode;
	logic [7:0] wdata_hi;
	logic [7:0] rdata;
	// dma request from device
	logic       dma_req;
	// serial link
	logic       txd;
	logic       rxd;
	logic       cts_n;
	modport device (
		input  addr, wdata, wdata_hi, wr, rd, word_mode, rxd, cts_n,
		output rdata, dma_req, txd
	);
	modport host (
		output addr, wdata, wdata_hi, wr, rd, word_mode, rxd, cts_n,
		input  rdata, dma_req, txd
	);
endinterface : hdlc_if

/* File: hw/hdlc_device.sv */
// hdlc channel transmit side: fifo window, command strobes, status
// assumes host drives the bus from clk; rxd and cts_n are asynchronous pins
`timescale 1ns/1ps
`include "hdlc_cfg.svh"
module hdlc_device (
	// clock and reset
	input  wire logic clk,
	input  wire logic arst_n,
	// host side
	hdlc_if.device    bus,
	// user side status
	output logic      tx_pool_ready_irq,
	output logic      all_sent_irq,
	output logic      timer_expired,
	output logic      remote_rnr_seen
);
	logic [7:0]  fifo_mem [0:31];
	logic [5:0]  fill_reg;
	logic [4:0]  rd_ptr_reg;
	logic        overflow_reg;
	logic [7:0]  mode_reg;
	logic [7:0]  timer_setting_reg;
	logic [7:0]  count_low_reg;
	logic [7:0]  count_high_reg;
	logic [11:0] remain_reg;
	logic [1:0]  busy_cnt_reg;
	logic        local_nr_reg;
	logic        await_ack_reg;
	logic        crc_pending_reg;
	logic        msg_end_reg;
	logic [15:0] timer_cnt_reg;
	logic        timer_run_reg;
	logic [2:0]  seq_reg;
	logic [2:0]  rx_sync_reg;
	logic [2:0]  cts_sync_reg;
	logic        rx_level_reg;
	logic        cts_level_reg;
	logic [7:0]  idle_cnt_reg;
	logic [7:0]  shift_reg;
	logic [2:0]  bit_cnt_reg;
	logic [3:0]  div_reg;
	logic [1:0]  hdr_cnt_reg;
	logic [7:0]  rx_shift_reg;
	hdlc_pkg::tx_state_t state_reg;
	logic        bit_en;
	logic        fifo_hit;
	logic        cmd_hit;
	logic        cmd_wr;
	logic        dma_mode;
	logic        take_byte;
	hdlc_pkg::controller_mode_t mode_sel;

	// address decode for channel a or b fifo window
	function automatic logic in_fifo(input logic [6:0] a);
		in_fifo = (a <= `FIFO_A_HI) ||
			(a >= `FIFO_B_LO && a <= `FIFO_B_HI);
	endfunction : in_fifo

	assign fifo_hit = bus.wr && in_fifo(bus.addr);
	assign cmd_hit  = (bus.addr == `STATUS_CMD_A) ||
		(bus.addr == `STATUS_CMD_B);
	assign cmd_wr   = bus.wr && cmd_hit && busy_cnt_reg == 2'h0;
	assign dma_mode = count_high_reg[`COUNT_DMA_BIT];
	assign mode_sel = hdlc_pkg::controller_mode_t'(
		mode_reg[`MODE_SEL_HI:`MODE_SEL_LO]);
	assign bit_en   = div_reg == 4'h0;
	assign take_byte = bit_en && bit_cnt_reg == 3'h7 &&
		(state_reg == hdlc_pkg::tx_data ||
		 state_reg == hdlc_pkg::tx_cyclic);

	// link bit-rate divider
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			div_reg <= 4'h0;
		end else begin
			div_reg <= bit_en ? `BIT_DIV : div_reg - 4'h1;
		end
	end

	// fifo storage, bytes or little-endian words
	always_ff @(posedge clk) begin
		if (fifo_hit && fill_reg < `FIFO_BYTES) begin
			fifo_mem[5'(rd_ptr_reg + fill_reg[4:0])] <= bus.wdata;
			if (bus.word_mode)
				fifo_mem[5'(rd_ptr_reg + fill_reg[4:0] + 5'h1)] <=
					bus.wdata_hi;
		end
	end

	// fill level and read pointer; cyclic mode keeps the contents
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fill_reg   <= 6'h0;
			rd_ptr_reg <= 5'h0;
		end else if (cmd_wr && bus.wdata[`CMD_TX_RESET]) begin
			fill_reg   <= 6'h0;
			rd_ptr_reg <= 5'h0;
		end else if (fifo_hit && fill_reg < `FIFO_BYTES) begin
			fill_reg <= fill_reg + (bus.word_mode ? 6'h2 : 6'h1);
		end else if (take_byte) begin
			rd_ptr_reg <= (rd_ptr_reg + 5'h1 == fill_reg[4:0] &&
				state_reg == hdlc_pkg::tx_cyclic) ? 5'h0 :
				rd_ptr_reg + 5'h1;
			if (state_reg == hdlc_pkg::tx_data)
				fill_reg <= fill_reg - 6'h1;
		end
	end

	// overflow flag: set wins over clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			overflow_reg <= 1'b0;
		end else if (fifo_hit && fill_reg >= `FIFO_BYTES) begin
			overflow_reg <= 1'b1;
		end else if ((cmd_wr && bus.wdata[`CMD_TX_RESET]) ||
				(take_byte && state_reg == hdlc_pkg::tx_data)) begin
			overflow_reg <= 1'b0;
		end
	end

	// config registers written from the host
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_reg          <= 8'h00;
			timer_setting_reg <= 8'h00;
			count_low_reg     <= 8'h00;
			count_high_reg    <= 8'h00;
		end else if (bus.wr) begin
			if (bus.addr == `MODE_A) mode_reg <= bus.wdata;
			if (bus.addr == `TIMER_A) timer_setting_reg <= bus.wdata;
			if (bus.addr == `COUNT_LOW_A) count_low_reg <= bus.wdata;
			if (bus.addr == `COUNT_HIGH_A) count_high_reg <= bus.wdata;
		end
	end

	// command busy window, strobes are not stored
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_cnt_reg <= 2'h0;
		end else if (cmd_wr) begin
			busy_cnt_reg <= 2'(`CMD_BUSY_CYC);
		end else if (busy_cnt_reg != 2'h0) begin
			busy_cnt_reg <= busy_cnt_reg - 2'h1;
		end
	end

	// auto-mode protocol state and receive-side commands
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			local_nr_reg  <= 1'b0;
			await_ack_reg <= 1'b0;
			seq_reg       <= 3'h0;
		end else if (cmd_wr) begin
			if (mode_sel == hdlc_pkg::mode_auto)
				local_nr_reg <= bus.wdata[`CMD_REPEAT];
			if (bus.wdata[`CMD_RX_RESET] &&
					mode_sel == hdlc_pkg::mode_auto)
				seq_reg <= 3'h0;
			if (bus.wdata[`CMD_RX_RELEASE] || bus.wdata[`CMD_RX_RESET])
				await_ack_reg <= 1'b0;
			if (bus.wdata[`CMD_SEND_IF] &&
					mode_sel == hdlc_pkg::mode_auto) begin
				await_ack_reg <= 1'b1;
				seq_reg       <= seq_reg + 3'h1;
			end
		end
	end

	// byte count for dma and block requests
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			remain_reg <= 12'h0;
			bus.dma_req <= 1'b0;
		end else begin
			if (cmd_wr && dma_mode && (bus.wdata[`CMD_SEND_TF] ||
					bus.wdata[`CMD_SEND_IF]))
				remain_reg <= {count_high_reg[3:0], count_low_reg};
			else if (fifo_hit && remain_reg != 12'h0)
				remain_reg <= remain_reg - 12'h1;
			bus.dma_req <= dma_mode && remain_reg != 12'h0 &&
				fill_reg == 6'h0;
		end
	end

	// timer: go starts, rewrite of setting stops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			timer_run_reg <= 1'b0;
			timer_cnt_reg <= 16'h0;
			timer_expired <= 1'b0;
		end else begin
			timer_expired <= 1'b0;
			if (bus.wr && bus.addr == `TIMER_A) begin
				timer_run_reg <= 1'b0;
			end else if (cmd_wr && bus.wdata[`CMD_TIMER_GO]) begin
				timer_run_reg <= 1'b1;
				timer_cnt_reg <= {3'h0, timer_setting_reg[4:0], 8'hff};
			end else if (timer_run_reg) begin
				timer_cnt_reg <= timer_cnt_reg - 16'h1;
				if (timer_cnt_reg == 16'h0) begin
					timer_run_reg <= 1'b0;
					timer_expired <= 1'b1;
				end
			end
		end
	end

	// three-stage pin synchronisers, change once stages two and three agree
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_sync_reg   <= 3'h7;
			cts_sync_reg  <= 3'h7;
			rx_level_reg  <= 1'b1;
			cts_level_reg <= 1'b1;
		end else begin
			rx_sync_reg  <= {rx_sync_reg[1:0], bus.rxd};
			cts_sync_reg <= {cts_sync_reg[1:0], bus.cts_n};
			if (rx_sync_reg[1] == rx_sync_reg[2])
				rx_level_reg <= rx_sync_reg[2];
			if (cts_sync_reg[1] == cts_sync_reg[2])
				cts_level_reg <= cts_sync_reg[2];
		end
	end

	// line activity: flag pattern or frame bits reset the idle count
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			idle_cnt_reg    <= `IDLE_LIMIT;
			rx_shift_reg    <= 8'hff;
			remote_rnr_seen <= 1'b0;
		end else if (bit_en) begin
			rx_shift_reg <= {rx_level_reg, rx_shift_reg[7:1]};
			if (rx_shift_reg != 8'hff)
				idle_cnt_reg <= 8'h0;
			else if (idle_cnt_reg != `IDLE_LIMIT)
				idle_cnt_reg <= idle_cnt_reg + 8'h1;
			if (rx_shift_reg == 8'h05)
				remote_rnr_seen <= 1'b1;
			else if (rx_shift_reg == 8'h01)
				remote_rnr_seen <= 1'b0;
		end
	end

	// status read, data one cycle after strobe
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bus.rdata <= `STATUS_RESET;
		end else if (bus.rd && cmd_hit) begin
			bus.rdata <= 8'h00;
			bus.rdata[`ST_OVERFLOW] <= overflow_reg;
			bus.rdata[`ST_WRITE_EN] <= fill_reg < `FIFO_BYTES &&
				state_reg != hdlc_pkg::tx_cyclic;
			bus.rdata[`ST_LOCAL_NR] <= mode_sel == hdlc_pkg::mode_auto &&
				local_nr_reg;
			bus.rdata[`ST_REMOTE_NR] <= mode_sel == hdlc_pkg::mode_auto &&
				remote_rnr_seen;
			bus.rdata[`ST_LINE_IDLE] <= idle_cnt_reg == `IDLE_LIMIT;
			bus.rdata[`ST_CMD_EXEC] <= busy_cnt_reg != 2'h0;
			bus.rdata[`ST_CTS] <= !cts_level_reg;
			bus.rdata[`ST_AWAIT_ACK] <= mode_sel == hdlc_pkg::mode_auto &&
				await_ack_reg;
		end else if (bus.rd && bus.addr == `MODE_A) begin
			bus.rdata <= mode_reg;
		end else begin
			bus.rdata <= 8'h00;
		end
	end

	// transmit sequencer
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg         <= hdlc_pkg::tx_idle;
			shift_reg         <= `FLAG_BYTE;
			bit_cnt_reg       <= 3'h0;
			hdr_cnt_reg       <= 2'h0;
			msg_end_reg       <= 1'b0;
			crc_pending_reg   <= 1'b0;
			bus.txd           <= 1'b1;
			tx_pool_ready_irq <= 1'b0;
			all_sent_irq      <= 1'b0;
		end else begin
			tx_pool_ready_irq <= 1'b0;
			all_sent_irq      <= 1'b0;
			if (cmd_wr && bus.wdata[`CMD_TX_RESET]) begin
				state_reg   <= hdlc_pkg::tx_abort;
				bit_cnt_reg <= 3'h0;
				tx_pool_ready_irq <= 1'b1;
			end else if (cmd_wr && state_reg == hdlc_pkg::tx_idle) begin
				if (bus.wdata == `CMD_CYCLIC &&
						mode_sel == hdlc_pkg::mode_ext_transparent) begin
					state_reg   <= hdlc_pkg::tx_cyclic;
					bit_cnt_reg <= 3'h0;
				end else if (bus.wdata[`CMD_SEND_TF] ||
						(bus.wdata[`CMD_SEND_IF] &&
						 mode_sel == hdlc_pkg::mode_auto)) begin
					state_reg   <= hdlc_pkg::tx_flag_open;
					hdr_cnt_reg <= bus.wdata[`CMD_SEND_IF] ? 2'h2 : 2'h0;
					msg_end_reg <= bus.wdata[`CMD_MSG_END] || dma_mode;
					shift_reg   <= `FLAG_BYTE;
					bit_cnt_reg <= 3'h0;
				end
			end else if (cmd_wr && bus.wdata[`CMD_MSG_END]) begin
				msg_end_reg <= 1'b1;
			end else if (bit_en) begin
				bit_cnt_reg <= bit_cnt_reg + 3'h1;
				case (state_reg)
				hdlc_pkg::tx_idle: begin
					bus.txd <= 1'b1;
				end
				hdlc_pkg::tx_flag_open: begin
					bus.txd   <= shift_reg[bit_cnt_reg];
					if (bit_cnt_reg == 3'h7) begin
						if (hdr_cnt_reg != 2'h0) begin
							hdr_cnt_reg <= hdr_cnt_reg - 2'h1;
							shift_reg   <= {seq_reg, 5'h0};
						end else if (!dma_mode ||
								fill_reg == `FIFO_BYTES ||
								remain_reg == 12'h0) begin
							state_reg <= hdlc_pkg::tx_data;
						end
					end
				end
				hdlc_pkg::tx_data: begin
					bus.txd <= fifo_mem[rd_ptr_reg][bit_cnt_reg];
					if (bit_cnt_reg == 3'h7 && fill_reg == 6'h1) begin
						if (msg_end_reg) begin
							state_reg       <= hdlc_pkg::tx_flag_close;
							crc_pending_reg <= 1'b1;
						end else begin
							state_reg <= hdlc_pkg::tx_idle;
							tx_pool_ready_irq <= 1'b1;
						end
					end
				end
				hdlc_pkg::tx_flag_close: begin
					bus.txd <= crc_pending_reg ? 1'b0 :
						1'(`FLAG_BYTE >> bit_cnt_reg);
					if (bit_cnt_reg == 3'h7) begin
						if (crc_pending_reg) begin
							crc_pending_reg <= 1'b0;
						end else begin
							state_reg    <= hdlc_pkg::tx_idle;
							msg_end_reg  <= 1'b0;
							all_sent_irq <= 1'b1;
						end
					end
				end
				hdlc_pkg::tx_abort: begin
					bus.txd <= 1'b1;
					if (bit_cnt_reg == `ABORT_ONES - 3'h1)
						state_reg <= hdlc_pkg::tx_idle;
				end
				hdlc_pkg::tx_cyclic: begin
					bus.txd <= fifo_mem[rd_ptr_reg][bit_cnt_reg];
				end
				default: begin
					state_reg <= hdlc_pkg::tx_idle;
				end
				endcase
			end
		end
	end
endmodule : hdlc_device

/* File: hw/hdlc_host.sv */
// host controller for the hdlc channel: runs queued orders on the bus
// assumes a user port on the same clock, one order at a time
`timescale 1ns/1ps
`include "hdlc_cfg.svh"
module hdlc_host (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// device side
	hdlc_if.host            bus,
	// user order port
	input  wire logic [6:0] user_addr,
	input  wire logic [7:0] user_wdata,
	input  wire logic [7:0] user_wdata_hi,
	input  wire logic       user_word,
	input  wire logic       user_wr,
	input  wire logic       user_rd,
	// user answer port
	output logic [7:0]      user_rdata,
	output logic            user_rvalid,
	output logic            user_busy,
	output logic [5:0]      bytes_loaded
);
	logic       poll_reg;
	logic       rd_wait_reg;
	logic [6:0] cmd_addr_reg;
	logic [7:0] cmd_data_reg;

	// bus driver: a command is held until busy flag reads clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bus.addr      <= 7'h00;
			bus.wdata     <= 8'h00;
			bus.wdata_hi  <= 8'h00;
			bus.wr        <= 1'b0;
			bus.rd        <= 1'b0;
			bus.word_mode <= 1'b0;
			poll_reg      <= 1'b0;
			cmd_addr_reg  <= 7'h00;
			cmd_data_reg  <= 8'h00;
			rd_wait_reg   <= 1'b0;
			user_busy     <= 1'b0;
		end else begin
			bus.wr <= 1'b0;
			bus.rd <= 1'b0;
			rd_wait_reg <= bus.rd && !poll_reg;
			if (poll_reg) begin
				if (!bus.rd && !bus.wr && !user_busy) begin
					bus.rd   <= 1'b1;
					bus.addr <= cmd_addr_reg;
					user_busy <= 1'b1;
				end else if (user_busy && !bus.rd) begin
					user_busy <= 1'b0;
					if (!bus.rdata[`ST_CMD_EXEC]) begin
						bus.wr    <= 1'b1;
						bus.wdata <= cmd_data_reg;
						poll_reg  <= 1'b0;
					end
				end
			end else if (user_wr && (user_addr == `STATUS_CMD_A ||
					user_addr == `STATUS_CMD_B)) begin
				poll_reg     <= 1'b1;
				cmd_addr_reg <= user_addr;
				cmd_data_reg <= user_wdata;
			end else if (user_wr) begin
				bus.wr        <= 1'b1;
				bus.addr      <= user_addr;
				bus.wdata     <= user_wdata;
				bus.wdata_hi  <= user_wdata_hi;
				bus.word_mode <= user_word;
			end else if (user_rd) begin
				bus.rd   <= 1'b1;
				bus.addr <= user_addr;
			end
		end
	end

	// link pins the host side models as a loopback partner: rxd follows txd, cts_n held low
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bus.rxd   <= 1'b1;
			bus.cts_n <= 1'b1;
		end else begin
			bus.rxd   <= bus.txd;
			bus.cts_n <= 1'b0;
		end
	end

	// count channel a bytes loaded since last command; 6-bit count, not limited to one window
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bytes_loaded <= 6'h0;
		end else if (bus.wr && (bus.addr == `STATUS_CMD_A ||
				bus.addr == `STATUS_CMD_B)) begin
			bytes_loaded <= 6'h0;
		end else if (bus.wr && bus.addr <= `FIFO_A_HI) begin
			bytes_loaded <= bytes_loaded + (bus.word_mode ? 6'h2 : 6'h1);
		end
	end

	// read answers two cycles after the bus strobe
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			user_rdata  <= 8'h00;
			user_rvalid <= 1'b0;
		end else begin
			user_rvalid <= rd_wait_reg;
			user_rdata  <= rd_wait_reg ? bus.rdata : 8'h00;
		end
	end
endmodule : hdlc_host

/* File: bench/hdlc_link_assertions.sv */
// checker for the register port and serial line between host and device
// assumes hdlc_if signals as plain inputs, one clock, byte writes
`timescale 1ns/1ps
`include "hdlc_cfg.svh"
module hdlc_link_assertions (
	// clock and reset
	input wire logic       clk,
	input wire logic       arst_n,
	// register port and line
	input wire logic [6:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic       word_mode,
	input wire logic [7:0] rdata,
	input wire logic       txd,
	input wire logic       cts_n
);
	logic       st;
	logic       cmd;
	logic       fifo;
	logic [2:0] since_cmd;
	logic [6:0] fill;
	logic [6:0] fill_cmd;
	logic [1:0] mode_sh;
	// decode of status/command and channel a fifo accesses
	assign st = addr == `STATUS_CMD_A || addr == `STATUS_CMD_B;
	assign cmd = wr && st;
	assign fifo = wr && addr <= `FIFO_A_HI;
	// cycles since a command write, saturating
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			since_cmd <= 3'h7;
		else if (cmd)
			since_cmd <= 3'h0;
		else if (since_cmd != 3'h7)
			since_cmd <= since_cmd + 3'h1;
	end
	// bytes written since the last transmitter reset
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			fill <= 7'h00;
		else if (cmd && wdata[`CMD_TX_RESET])
			fill <= 7'h00;
		else if (fifo && fill < 7'h40)
			fill <= fill + 7'h01 + {6'h00, word_mode};
	end
	// bytes written since any command
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			fill_cmd <= 7'h00;
		else if (cmd)
			fill_cmd <= 7'h00;
		else if (fifo && fill_cmd < 7'h40)
			fill_cmd <= fill_cmd + 7'h01 + {6'h00, word_mode};
	end
	// shadow of the mode field
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			mode_sh <= 2'h0;
		else if (wr && addr == `MODE_A)
			mode_sh <= wdata[7:6];
	end
	property p_cec_clear;
		@(posedge clk) disable iff (!arst_n)
		rd && st && since_cmd >= 3'h3 |=> !rdata[`ST_CMD_EXEC];
	endproperty
	a_cec_clear: assert property (p_cec_clear)
		else $error("command busy flag held too long");
	property p_cts;
		@(posedge clk) disable iff (!arst_n)
		rd && st && $stable(cts_n) && cts_n == $past(cts_n, 2)
			&& cts_n == $past(cts_n, 3) |=> rdata[`ST_CTS] == !$past(cts_n);
	endproperty
	a_cts: assert property (p_cts)
		else $error("clear to send bit wrong");
	property p_abort;
		@(posedge clk) disable iff (!arst_n)
		cmd && wdata[`CMD_TX_RESET] && since_cmd >= 3'h3 |-> ##8 txd [*8];
	endproperty
	a_abort: assert property (p_abort)
		else $error("abort ones missing");
	property p_send_start;
		@(posedge clk) disable iff (!arst_n)
		cmd && wdata[`CMD_SEND_TF] && !wdata[`CMD_TX_RESET]
			&& since_cmd >= 3'h3 |-> ##[1:40] !txd;
	endproperty
	a_send_start: assert property (p_send_start)
		else $error("send did not start");
	property p_no_ovf;
		@(posedge clk) disable iff (!arst_n)
		rd && st && fill <= 7'h20 |=> !rdata[`ST_OVERFLOW];
	endproperty
	a_no_ovf: assert property (p_no_ovf)
		else $error("overflow without excess bytes");
	property p_ovf;
		@(posedge clk) disable iff (!arst_n)
		rd && st && fill_cmd > 7'h20 |=> rdata[`ST_OVERFLOW];
	endproperty
	a_ovf: assert property (p_ovf)
		else $error("overflow not flagged");
	property p_mode;
		@(posedge clk) disable iff (!arst_n)
		rd && addr == `MODE_A |=> rdata[7:6] == mode_sh;
	endproperty
	a_mode: assert property (p_mode)
		else $error("mode field readback wrong");
	property p_wen;
		@(posedge clk) disable iff (!arst_n)
		rd && st && fill == 7'h00 && since_cmd >= 3'h3
			|=> rdata[`ST_WRITE_EN];
	endproperty
	a_wen: assert property (p_wen)
		else $error("write enable missing on empty fifo");
endmodule : hdlc_link_assertions

/* File: bench/hdlc_tx_fifo_command_status_test.sv */
// testbench: host and device joined by hdlc_if, orders on the user port
// assumes 100 ns clock, byte mode, host polls busy before commands
`timescale 1ns/1ps
`include "hdlc_cfg.svh"
module hdlc_tx_fifo_command_status_test;
	logic       clk;
	logic       arst_n;
	logic [6:0] user_addr;
	logic [7:0] user_wdata;
	logic       user_wr;
	logic       user_rd;
	logic [7:0] user_rdata;
	logic       user_rvalid;
	logic       user_busy;
	logic       pool_irq;
	logic       irq_seen;
	logic [7:0] got;
	int         fail_count;
	int         n_tests;
	int         cycles;
	hdlc_if link ();
	hdlc_device i_hdlc_device (.clk(clk), .arst_n(arst_n), .bus(link),
		.tx_pool_ready_irq(pool_irq), .all_sent_irq(),
		.timer_expired(), .remote_rnr_seen());
	hdlc_host i_hdlc_host (.clk(clk), .arst_n(arst_n), .bus(link),
		.user_addr(user_addr), .user_wdata(user_wdata),
		.user_wdata_hi(8'h00), .user_word(1'b0), .user_wr(user_wr),
		.user_rd(user_rd), .user_rdata(user_rdata),
		.user_rvalid(user_rvalid), .user_busy(user_busy),
		.bytes_loaded());
	hdlc_link_assertions i_hdlc_link_assertions (.clk(clk),
		.arst_n(arst_n), .addr(link.addr), .wdata(link.wdata),
		.wr(link.wr), .rd(link.rd), .word_mode(link.word_mode),
		.rdata(link.rdata), .txd(link.txd), .cts_n(link.cts_n));
	// clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// watchdog and pool-ready capture
	always @(posedge clk) begin
		cycles++;
		if (pool_irq === 1'b1)
			irq_seen = 1'b1;
		if (cycles == 20000) begin
			fail_count++;
			close_out();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic put(input logic [6:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		user_addr <= a;
		user_wdata <= d;
		user_wr <= 1'b1;
		@(posedge clk);
		user_wr <= 1'b0;
		// a command order raises busy only two edges later
		repeat (2) @(negedge clk);
		do begin
			@(negedge clk);
			n++;
		end while (user_busy !== 1'b0 && n < 200);
	endtask : put
	task automatic get(input logic [6:0] a, output logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		user_addr <= a;
		user_rd <= 1'b1;
		@(posedge clk);
		user_rd <= 1'b0;
		do begin
			@(negedge clk);
			n++;
		end while (user_rvalid !== 1'b1 && n < 10);
		d = user_rdata;
	endtask : get
	// wait for the first low bit, then sample once per bit time
	task automatic serial(input logic [7:0] pat, input int first,
		input int nbits);
		int n;
		n = 0;
		while (link.txd !== 1'b0 && n < 400) begin
			@(negedge clk);
			n++;
		end
		for (int i = 0; i < nbits; i++) begin
			check({7'h00, link.txd}, {7'h00, pat[(first + i) % 8]});
			repeat (4) @(negedge clk);
		end
	endtask : serial
	// transmitter reset: ones on the line, pool ready, overflow gone
	task automatic abort_check;
		irq_seen = 1'b0;
		put(`STATUS_CMD_A, 8'h01);
		repeat (8) @(negedge clk);
		for (int i = 0; i < 16; i++) begin
			check({7'h00, link.txd}, 8'h01);
			@(negedge clk);
		end
		check({7'h00, irq_seen}, 8'h01);
		get(`STATUS_CMD_A, got);
		check(got & 8'h84, 8'h00);
	endtask : abort_check
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out
	// main sequence
	initial begin
		arst_n = 1'b0;
		user_addr = 7'h00;
		user_wdata = 8'h00;
		user_wr = 1'b0;
		user_rd = 1'b0;
		irq_seen = 1'b0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		get(`STATUS_CMD_A, got);
		check(got & 8'hfd, `STATUS_RESET);
		$display("test status reset done");
		for (int m = 0; m < 4; m++) begin
			put(`MODE_A, {2'(m), 6'h00});
			get(`MODE_A, got);
			check(got, {2'(m), 6'h00});
		end
		$display("test mode select done");
		for (int i = 0; i < 33; i++) begin
			if (i == 32) begin
				get(`STATUS_CMD_A, got);
				check(got & 8'h80, 8'h00);
			end
			put(7'(i % 32), 8'(i));
		end
		get(`STATUS_CMD_A, got);
		check(got & 8'h80, 8'h80);
		abort_check();
		$display("test overflow and abort done");
		put(`MODE_A, 8'h40);
		put(7'h05, 8'h11);
		put(7'h1f, 8'h22);
		put(`STATUS_CMD_A, 8'h0a);
		serial(`FLAG_BYTE, 0, 8);
		abort_check();
		$display("test framed send done");
		put(`MODE_A, 8'hc0);
		put(7'h10, 8'h0b);
		put(`STATUS_CMD_A, `CMD_CYCLIC);
		serial(8'h0b, 2, 24);
		abort_check();
		$display("test cyclic send done");
		close_out();
	end
endmodule : hdlc_tx_fifo_command_status_test
